/* common/ldl_pkg.sv */
// constants and carrier types for the descriptor list handler
`default_nettype none
package ldl_pkg;
   // ***************************************
   // register offsets and fields
   // ***************************************
   localparam logic [7:0]  REG_RXBASE = 8'h00;
   localparam logic [7:0]  REG_TXBASE = 8'h04;
   localparam logic [7:0]  REG_MODE   = 8'h08;
   localparam logic [7:0]  REG_STAT   = 8'h0C;
   localparam logic [7:0]  REG_RXPTR  = 8'h10;
   localparam logic [7:0]  REG_TXPTR  = 8'h14;
   localparam logic [31:0] BASE_RST   = 32'h0;
   localparam logic [31:0] MODE_RST   = 32'h0;
   localparam int          MODE_RXEN  = 0;
   localparam int          MODE_TXEN  = 1;
   localparam int          MODE_LBPOS = 10;
   localparam logic [1:0]  LB_INTERN  = 2'h1;
   localparam int          ST_TXINT   = 0;
   localparam int          ST_JAB     = 3;
   localparam int          ST_UNF     = 5;
   // ***************************************
   // descriptor layout
   // ***************************************
   localparam logic [31:0] OFS_W1     = 32'h4;
   localparam logic [31:0] OFS_W2     = 32'h8;
   localparam logic [31:0] OFS_W3     = 32'hC;
   localparam logic [31:0] DESC_STEP  = 32'h10;
   localparam int          D_OWN      = 31;
   localparam int          D_RING     = 25;
   localparam int          D_CHAIN    = 24;
   localparam int          SZ2_POS    = 11;
   localparam int          SZ1_POS    = 0;
   localparam int          SZ_W       = 11;
   localparam int          RX_FILT    = 30;
   localparam int          RX_ERRSUM  = 15;
   localparam int          RX_RUNT    = 11;
   localparam int          RX_FIRST   = 9;
   localparam int          RX_LAST    = 8;
   localparam int          RX_COLL    = 6;
   localparam int          RX_KIND    = 5;
   localparam int          RX_WDOG    = 4;
   localparam int          RX_PHY     = 3;
   localparam int          RX_ODD     = 2;
   localparam int          RX_CRC     = 1;
   localparam int          RX_OVF     = 0;
   localparam int          TX_ERRSUM  = 15;
   localparam int          TX_JAB     = 14;
   localparam int          TX_LOST    = 11;
   localparam int          TX_NOCAR   = 10;
   localparam int          TX_LATE    = 9;
   localparam int          TX_EXC     = 8;
   localparam int          TX_HB      = 7;
   localparam int          TX_UNF     = 1;
   localparam int          TX_DEF     = 0;
   typedef struct packed {
      logic overflow, watchdog, lateColl, runt, shortRunt, frameKind;
      logic filterFail, oddBits, crcErr, phyErr, collSeen, firstDesc, lastDesc;
   } ldl_rxstat_type;
   typedef struct packed {
      logic underflow, exColl, lateColl, noCarrier, lostCarrier;
      logic jabber, heartbeat, deferred;
   } ldl_txstat_type;
endpackage
`default_nettype wire

/* rtl/ldl_desc_engine.sv */
// descriptor list walker for receive and transmit with APB control
//
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none
module ldl_desc_engine (
   input  wire logic                  clk_sys,    // system clock
   input  wire logic                  rst_n,      // async reset
   input  wire logic                  psel,       // apb select
   input  wire logic                  penable,    // apb enable
   input  wire logic                  pwrite,     // apb direction
   input  wire logic [7:0]            paddr,      // apb address
   input  wire logic [31:0]           pwdata,     // apb write data
   output logic      [31:0]           prdata,     // apb read data
   output logic                       pready,     // apb ready
   output logic                       pslverr,    // apb error
   output logic                       memReq,     // memory request
   output logic                       memWe,      // memory write
   output logic      [31:0]           memAddr,    // memory address
   output logic      [31:0]           memWdata,   // memory write data
   input  wire logic                  memAck,     // memory done
   input  wire logic [31:0]           memRdata,   // memory read data
   output logic                       bufValid,   // buffer offered
   output logic                       bufTx,      // buffer is transmit
   output logic      [31:0]           bufAddr,    // buffer address
   output logic      [10:0]           bufSize,    // buffer bytes
   input  wire logic                  bufTaken,   // buffer accepted
   input  wire logic                  rxDone,     // rx descriptor done
   input  wire ldl_pkg::ldl_rxstat_type rxStat,   // rx completion status
   input  wire logic                  txDone,     // tx descriptor done
   input  wire ldl_pkg::ldl_txstat_type txStat    // tx completion status
);
   typedef enum logic [3:0] {
      S_IDLE, S_RD0, S_RD1, S_RD2, S_RD3, S_BUF1, S_BUF2, S_WAIT, S_WB
   } ldl_state_type;

   // ***************************************
   // functions
   // ***************************************
   function automatic logic [31:0] nextDesc(input logic [31:0] w1, a2, base, ptr);
      if (w1[ldl_pkg::D_RING])
         return base;
      else if (w1[ldl_pkg::D_CHAIN])
         return a2;
      else
         return ptr + ldl_pkg::DESC_STEP;
   endfunction

   function automatic logic [31:0] rxWord(input ldl_pkg::ldl_rxstat_type s);
      logic [31:0] w;
      logic badTail;
      logic l;
      w = 32'h0;
      l = s.lastDesc;
      badTail = s.overflow | s.watchdog;
      w[ldl_pkg::RX_LAST] = l;
      w[ldl_pkg::RX_FIRST] = s.firstDesc;
      w[ldl_pkg::RX_RUNT] = l & s.runt & ~badTail & ~s.lateColl;
      w[ldl_pkg::RX_ODD] = l & s.oddBits & ~badTail;
      w[ldl_pkg::RX_CRC] = l & s.crcErr & ~badTail;
      w[ldl_pkg::RX_KIND] = l & s.frameKind & ~s.shortRunt;
      w[ldl_pkg::RX_FILT] = l & s.filterFail & ~s.shortRunt;
      w[ldl_pkg::RX_COLL] = l & s.collSeen;
      w[ldl_pkg::RX_WDOG] = l & s.watchdog;
      w[ldl_pkg::RX_PHY] = l & s.phyErr;
      w[ldl_pkg::RX_OVF] = l & s.overflow;
      w[ldl_pkg::RX_ERRSUM] = w[ldl_pkg::RX_RUNT] | w[ldl_pkg::RX_COLL] | w[ldl_pkg::RX_CRC]
                            | w[ldl_pkg::RX_OVF] | w[ldl_pkg::RX_PHY];
      return w; // own bit stays clear
   endfunction

   function automatic logic [31:0] txWord(input ldl_pkg::ldl_txstat_type s, input logic lb);
      logic [31:0] w;
      w = 32'h0;
      w[ldl_pkg::TX_UNF] = s.underflow;
      w[ldl_pkg::TX_EXC] = s.exColl;
      w[ldl_pkg::TX_LATE] = s.lateColl & ~s.underflow;
      w[ldl_pkg::TX_NOCAR] = s.noCarrier & ~lb;
      w[ldl_pkg::TX_LOST] = s.lostCarrier & ~lb;
      w[ldl_pkg::TX_JAB] = s.jabber;
      w[ldl_pkg::TX_HB] = s.heartbeat & ~s.jabber & ~s.underflow;
      w[ldl_pkg::TX_DEF] = s.deferred;
      w[ldl_pkg::TX_ERRSUM] = w[ldl_pkg::TX_UNF] | w[ldl_pkg::TX_EXC] | w[ldl_pkg::TX_LATE]
                            | w[ldl_pkg::TX_NOCAR] | w[ldl_pkg::TX_LOST]
                            | w[ldl_pkg::TX_JAB];
      return w;
   endfunction

   // ***************************************
   // registers
   // ***************************************
   ldl_state_type st_r, st_nxt;
   logic        dir_r, dir_nxt;
   logic [31:0] rxBase_r, txBase_r, mode_r, stat_r;
   logic [31:0] rxPtr_r, txPtr_r, w1_r, a1_r, a2_r;
   logic [31:0] addr_nxt, wdata_nxt;
   logic        txHalt_r;

   // ***************************************
   // decode
   // ***************************************
   wire         apbWr   = psel & penable & pwrite;
   wire         mapped  = paddr <= ldl_pkg::REG_TXPTR && paddr[1:0] == 2'h0;
   wire         wrBase  = apbWr & paddr == ldl_pkg::REG_RXBASE;
   wire         wrTbase = apbWr & paddr == ldl_pkg::REG_TXBASE;
   wire         wrMode  = apbWr & paddr == ldl_pkg::REG_MODE;
   wire         wrStat  = apbWr & paddr == ldl_pkg::REG_STAT;
   wire         rxRun   = mode_r[ldl_pkg::MODE_RXEN];
   wire         txRun   = mode_r[ldl_pkg::MODE_TXEN] & ~txHalt_r;
   wire         lbInt   = mode_r[ldl_pkg::MODE_LBPOS +: 2] == ldl_pkg::LB_INTERN;
   wire         pickTx  = txRun & (~rxRun | ~dir_r);
   wire [31:0]  curPtr  = dir_r ? txPtr_r : rxPtr_r;
   wire [31:0]  curBase = dir_r ? txBase_r : rxBase_r;
   wire [10:0]  size1   = w1_r[ldl_pkg::SZ1_POS +: ldl_pkg::SZ_W];
   wire [10:0]  size2   = w1_r[ldl_pkg::SZ2_POS +: ldl_pkg::SZ_W];
   wire         skip2   = w1_r[ldl_pkg::D_CHAIN] | size2 == 11'h0;
   wire         done    = dir_r ? txDone : rxDone;
   wire         capTx   = st_r == S_WAIT & dir_r & txDone;
   wire         setJab  = capTx & txStat.jabber;
   wire         setUnf  = capTx & txStat.underflow;
   wire         wbDone  = st_r == S_WB & memAck;
   wire [31:0]  nxtPtr  = nextDesc(w1_r, a2_r, curBase, curPtr);

   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign memReq   = st_r inside {S_RD0, S_RD1, S_RD2, S_RD3, S_WB};
   assign memWe    = st_r == S_WB;
   assign bufTx    = dir_r;
   assign bufValid = (st_r == S_BUF1 & size1 != 11'h0)
                   | (st_r == S_BUF2 & ~skip2);
   assign bufAddr  = st_r == S_BUF2 ? a2_r : a1_r;
   assign bufSize  = st_r == S_BUF2 ? size2 : size1;

   always_comb begin
      unique case (paddr)
         ldl_pkg::REG_RXBASE: prdata = rxBase_r;
         ldl_pkg::REG_TXBASE: prdata = txBase_r;
         ldl_pkg::REG_MODE:   prdata = mode_r;
         ldl_pkg::REG_STAT:   prdata = stat_r;
         ldl_pkg::REG_RXPTR:  prdata = rxPtr_r;
         ldl_pkg::REG_TXPTR:  prdata = txPtr_r;
         default:             prdata = 32'h0;
      endcase
   end

   // ***************************************
   // walker state machine
   // ***************************************
   always_comb begin
      st_nxt = st_r;
      dir_nxt = dir_r;
      addr_nxt = memAddr;
      wdata_nxt = memWdata;
      unique case (st_r)
         S_IDLE: begin
            if (pickTx) begin
               dir_nxt = 1'b1;
               addr_nxt = txPtr_r;
               st_nxt = S_RD0;
            end else if (rxRun) begin
               dir_nxt = 1'b0;
               addr_nxt = rxPtr_r;
               st_nxt = S_RD0;
            end
         end
         S_RD0: begin
            if (memAck) begin
               // not ours yet: drop back and poll again later
               st_nxt = memRdata[ldl_pkg::D_OWN] ? S_RD1 : S_IDLE;
               addr_nxt = curPtr + ldl_pkg::OFS_W1;
            end
         end
         S_RD1: begin
            if (memAck) begin
               st_nxt = S_RD2;
               addr_nxt = curPtr + ldl_pkg::OFS_W2;
            end
         end
         S_RD2: begin
            if (memAck) begin
               st_nxt = S_RD3;
               addr_nxt = curPtr + ldl_pkg::OFS_W3;
            end
         end
         S_RD3: begin
            if (memAck)
               st_nxt = S_BUF1;
         end
         S_BUF1: begin
            if (size1 == 11'h0 || bufTaken)
               st_nxt = S_BUF2;
         end
         S_BUF2: begin
            if (skip2 || bufTaken)
               st_nxt = S_WAIT;
         end
         S_WAIT: begin
            if (done) begin
               st_nxt = S_WB;
               addr_nxt = curPtr;
               wdata_nxt = dir_r ? txWord(txStat, lbInt) : rxWord(rxStat);
            end
         end
         S_WB: begin
            if (memAck)
               st_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= S_IDLE;
         dir_r <= 1'b0;
         memAddr <= 32'h0;
         memWdata <= 32'h0;
      end else begin
         st_r <= st_nxt;
         dir_r <= dir_nxt;
         memAddr <= addr_nxt;
         memWdata <= wdata_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w1_r <= 32'h0;
         a1_r <= 32'h0;
         a2_r <= 32'h0;
      end else begin
         if (st_r == S_RD1 && memAck)
            w1_r <= memRdata;
         if (st_r == S_RD2 && memAck)
            a1_r <= memRdata;
         if (st_r == S_RD3 && memAck)
            a2_r <= memRdata;
      end
   end

   // ***************************************
   // software registers and pointers
   // ***************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxBase_r <= ldl_pkg::BASE_RST;
         txBase_r <= ldl_pkg::BASE_RST;
         rxPtr_r <= ldl_pkg::BASE_RST;
         txPtr_r <= ldl_pkg::BASE_RST;
         mode_r <= ldl_pkg::MODE_RST;
      end else begin
         if (wrMode)
            mode_r <= pwdata;
         // base write restarts the list; pointer change mid-walk is on software
         if (wrBase)
            rxBase_r <= pwdata;
         if (wrTbase)
            txBase_r <= pwdata;
         if (wrBase)
            rxPtr_r <= pwdata;
         else if (wbDone && !dir_r)
            rxPtr_r <= nxtPtr;
         if (wrTbase)
            txPtr_r <= pwdata;
         else if (wbDone && dir_r)
            txPtr_r <= nxtPtr;
      end
   end

   // events win over a same-cycle write-one-to-clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= 32'h0;
         txHalt_r <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~({32{wrStat}} & pwdata))
                 | (32'(setJab) << ldl_pkg::ST_JAB)
                 | (32'(setUnf) << ldl_pkg::ST_UNF)
                 | (32'(setUnf) << ldl_pkg::ST_TXINT);
         if (setJab || setUnf)
            txHalt_r <= 1'b1;
         else if (wrMode)
            txHalt_r <= 1'b0;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_ring_wrap: assert property (
      wbDone && w1_r[ldl_pkg::D_RING] |=> curPtr == $past(curBase))
      else $error("ring end did not return to base");
   chk_chain_next: assert property (
      wbDone && w1_r[ldl_pkg::D_CHAIN] && !w1_r[ldl_pkg::D_RING]
      |=> curPtr == $past(a2_r))
      else $error("chained descriptor not followed");
   chk_skip_two: assert property (
      st_r == S_BUF2 && skip2 |-> !bufValid ##1 st_r == S_WAIT)
      else $error("second buffer not skipped");
   chk_skip_one: assert property (
      st_r == S_BUF1 && size1 == 11'h0 |-> !bufValid ##1 st_r == S_BUF2)
      else $error("empty first buffer offered");
   chk_own_status: assert property (
      st_r == S_WAIT && done |=> memWe && !memWdata[ldl_pkg::D_OWN]
      && memWdata == $past(dir_r ? txWord(txStat, lbInt) : rxWord(rxStat)))
      else $error("status not written with ownership release");
   chk_tx_summary: assert property (
      capTx && (txStat.underflow || txStat.exColl || txStat.jabber)
      |=> memWdata[ldl_pkg::TX_ERRSUM])
      else $error("error summary missing");
   chk_jab_stop: assert property (
      setJab |=> stat_r[ldl_pkg::ST_JAB] && !txRun && !memWdata[ldl_pkg::TX_HB])
      else $error("jabber did not stop transmit");
   chk_unf_susp: assert property (
      setUnf |=> stat_r[ldl_pkg::ST_UNF] && stat_r[ldl_pkg::ST_TXINT]
      && txHalt_r && memWdata[ldl_pkg::TX_UNF])
      else $error("underflow did not suspend transmit");
   chk_rx_badtail: assert property (
      st_r == S_WAIT && !dir_r && rxDone
      && (rxStat.overflow || rxStat.watchdog || rxStat.lateColl)
      |=> !memWdata[ldl_pkg::RX_RUNT])
      else $error("runt reported on bad tail");
   chk_loop_mask: assert property (
      capTx && lbInt |=> !memWdata[ldl_pkg::TX_LOST] && !memWdata[ldl_pkg::TX_NOCAR])
      else $error("carrier flags in loopback");
endmodule
`default_nettype wire

/* tb/ldl_host_mem.sv */
// host memory model serving descriptor reads and status write-backs
`default_nettype none
module ldl_host_mem (
   input  wire logic        clk_sys,   // system clock
   input  wire logic        rst_n,     // async reset
   input  wire logic        memReq,    // access request
   input  wire logic        memWe,     // access is a write
   input  wire logic [31:0] memAddr,   // byte address
   input  wire logic [31:0] memWdata,  // write data
   output logic             memAck,    // access done
   output logic      [31:0] memRdata   // read data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [0:255];
   logic [1:0]  waitCnt;
   logic        slow;
   wire  [1:0]  lat = slow ? 2'h3 : 2'h0;
   initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   // no stale word outside the acked cycle, so a late sample reads garbage
   assign memRdata = memAck ? mem[memAddr[9:2]] : ~mem[memAddr[9:2]];
   // ************************************************
   // answers alternate between prompt and slow
   // ************************************************
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         memAck <= 1'b0;
         waitCnt <= 2'h0;
         slow <= 1'b0;
      end else begin
         memAck <= memReq && !memAck && (waitCnt >= lat);
         waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
         if (memAck) slow <= !slow;
         if (memAck && memWe) mem[memAddr[9:2]] <= memWdata;
      end
   end
endmodule
`default_nettype wire

/* tb/lan_descriptor_list_handling_tb.sv */
// testbench for the descriptor list handler
`default_nettype none
module lan_descriptor_list_handling_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, bufAddr, q, w;
   logic memReq, memWe, memAck, bufValid, bufTx, bufTaken, rxDone, txDone;
   logic [10:0] bufSize;
   ldl_pkg::ldl_rxstat_type rxStat;
   ldl_pkg::ldl_txstat_type txStat;
   int n_fail = 0;
   int check_count = 0;
   logic [7:0]  txIn [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h06, 8'h18};
   logic [15:0] txMsk [7] = '{16'h8002, 16'h8100, 16'h8200, 16'h8400, 16'h8800,
                              16'hC080, 16'h0C00};
   logic [15:0] txVal [7] = '{16'h8002, 16'h8100, 16'h8200, 16'h8400, 16'h8800,
                              16'hC000, 16'h0000};
   ldl_desc_engine uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .bufValid(bufValid),
      .bufTx(bufTx), .bufAddr(bufAddr), .bufSize(bufSize), .bufTaken(bufTaken),
      .rxDone(rxDone), .rxStat(rxStat), .txDone(txDone), .txStat(txStat));
   ldl_host_mem host (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
   always #12.5 clk_sys = ~clk_sys;
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic guard(inout int k);
      k++;
      if (k > 400) begin
         n_fail++;
         $display("ERROR wait limit ran out");
         print_verdict();
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         guard(k);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // words 1..3 first, ownership last, so no half-built descriptor is fetched
   task automatic put_desc(input logic [31:0] at, w1, a1, a2);
      host.mem[at[9:2] + 8'h1] = w1;
      host.mem[at[9:2] + 8'h2] = a1;
      host.mem[at[9:2] + 8'h3] = a2;
      host.mem[at[9:2]] = 32'h8000_0000;
   endtask
   task automatic take(input logic tx, input logic [31:0] a, input logic [10:0] s);
      int k = 0;
      do begin
         @(posedge clk_sys);
         guard(k);
      end while (bufValid !== 1'b1);
      chk("bufTx", {31'h0, bufTx}, {31'h0, tx});
      chk("bufAddr", bufAddr, a);
      chk("bufSize", {21'h0, bufSize}, {21'h0, s});
      bufTaken <= 1'b1;
      @(posedge clk_sys);
      bufTaken <= 1'b0;
   endtask
   // completion held until the write-back starts; other states ignore it
   task automatic finish_desc(input logic tx, input logic [31:0] at);
      int k = 0;
      if (tx) txDone <= 1'b1;
      else rxDone <= 1'b1;
      do begin
         @(posedge clk_sys);
         guard(k);
      end while (!(memReq === 1'b1 && memWe === 1'b1));
      chk("wbAddr", memAddr, at);
      rxDone <= 1'b0;
      txDone <= 1'b0;
      do begin
         @(posedge clk_sys);
         guard(k);
      end while (host.mem[at[9:2]][31] !== 1'b0);
      w = host.mem[at[9:2]];
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, bufTaken, rxDone, txDone} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      rxStat = '0;
      txStat = '0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, ldl_pkg::REG_MODE, 32'h0);
      chk("modeReset", q, ldl_pkg::MODE_RST);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", {31'h0, e}, 32'h1);
      chk("unmappedData", q, 32'h0);
      apb(1'b0, 8'h02, 32'h0);
      chk("unaligned", {31'h0, e}, 32'h1);
      put_desc(32'h100, 32'h0001_0040, 32'h0000_1000, 32'h0000_2000);
      put_desc(32'h110, 32'h0000_8000, 32'h0000_1100, 32'h0000_2100);
      put_desc(32'h120, 32'h0101_8008, 32'h0000_1200, 32'h0000_0180);
      put_desc(32'h180, 32'h0300_0004, 32'h0000_1300, 32'h0000_2300);
      apb(1'b1, ldl_pkg::REG_RXBASE, 32'h100);
      apb(1'b0, ldl_pkg::REG_RXBASE, 32'h0);
      chk("rxBase", q, 32'h100);
      apb(1'b1, ldl_pkg::REG_MODE, 32'h1);
      take(1'b0, 32'h1000, 11'h040);
      take(1'b0, 32'h2000, 11'h020);
      rxStat <= '{overflow:1'b1, runt:1'b1, oddBits:1'b1, crcErr:1'b1, lastDesc:1'b1,
                  default:1'b0};
      finish_desc(1'b0, 32'h100);
      chk("rxOverflow", w & 32'h8000_8901, 32'h0000_8101);
      apb(1'b0, ldl_pkg::REG_RXPTR, 32'h0);
      chk("rxNext", q, 32'h110);
      take(1'b0, 32'h2100, 11'h010);
      rxStat <= '{frameKind:1'b1, default:1'b0};
      finish_desc(1'b0, 32'h110);
      chk("rxMiddle", w & 32'h8000_0120, 32'h0);
      take(1'b0, 32'h1200, 11'h008);
      rxStat <= '{lateColl:1'b1, collSeen:1'b1, runt:1'b1, lastDesc:1'b1, default:1'b0};
      finish_desc(1'b0, 32'h120);
      chk("rxLateColl", w & 32'h8000_0940, 32'h0000_0140);
      apb(1'b0, ldl_pkg::REG_RXPTR, 32'h0);
      chk("rxChain", q, 32'h180);
      take(1'b0, 32'h1300, 11'h004);
      rxStat <= '{runt:1'b1, shortRunt:1'b1, frameKind:1'b1, filterFail:1'b1,
                  lastDesc:1'b1, default:1'b0};
      finish_desc(1'b0, 32'h180);
      chk("rxShortRunt", w & 32'hC000_0920, 32'h0000_0900);
      apb(1'b0, ldl_pkg::REG_RXPTR, 32'h0);
      chk("rxRingWins", q, 32'h100);
      rxStat <= '0;
      // single transmit descriptor with ring-end set, re-armed each round
      put_desc(32'h200, 32'h0200_003C, 32'h0000_1400, 32'h0000_2400);
      apb(1'b1, ldl_pkg::REG_TXBASE, 32'h200);
      for (int i = 0; i < 7; i++) begin
         host.mem[8'h80] = 32'h8000_0000;
         apb(1'b1, ldl_pkg::REG_MODE, (i == 6) ? 32'h0000_0402 : 32'h0000_0002);
         take(1'b1, 32'h1400, 11'h03C);
         txStat <= ldl_pkg::ldl_txstat_type'(txIn[i]);
         finish_desc(1'b1, 32'h200);
         txStat <= '0;
         q = w & {16'h8000, txMsk[i]};
         chk("txWord0", q, {16'h0, txVal[i]});
         apb(1'b0, ldl_pkg::REG_TXPTR, 32'h0);
         chk("txRing", q, 32'h200);
         if (i == 0 || i == 5) begin
            apb(1'b0, ldl_pkg::REG_STAT, 32'h0);
            chk("status", q & 32'h29, (i == 0) ? 32'h21 : 32'h08);
            apb(1'b1, ldl_pkg::REG_STAT, 32'h29);
            // a halted transmitter must leave a newly armed descriptor alone
            host.mem[8'h80] = 32'h8000_0000;
            repeat (40) @(posedge clk_sys);
            chk("txHalted", {31'h0, host.mem[8'h80][31]}, 32'h1);
         end
      end
      // reset in mid-run: software registers must come back to their reset values
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, ldl_pkg::REG_TXBASE, 32'h0);
      chk("txBaseReset", q, ldl_pkg::BASE_RST);
      apb(1'b0, ldl_pkg::REG_MODE, 32'h0);
      chk("modeReset2", q, ldl_pkg::MODE_RST);
      print_verdict();
   end
endmodule
`default_nettype wire
